// ---- sim/uart_frame_control_status_tb.sv ----
/*
  uart_frame_control_status_tb: self-checking bench for ufcs_top.
  drives CE high except during the final freeze check, with a remote transceiver model on the pins.
*/
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end
module uart_frame_control_status_tb
  import ufcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [13:0] A_CTL = 14'(UFCS_IDX_CTRL0 * 4);
  localparam logic [13:0] A_ST  = 14'(UFCS_IDX_STAT1 * 4);
  localparam logic [13:0] A_IS  = 14'(UFCS_IDX_IRQST * 4);
  localparam logic [13:0] A_IM  = 14'(UFCS_IDX_IRQMSK * 4);
  localparam logic [1:0]  OK    = UFCS_RESP_OKAY;
  logic        clk = 0, rst = 1, ce = 1;
  logic [13:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0]  wstrb = '0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        chr = 0, first = 0, mp = 0, drd = 0, txc = 1, send = 0, stall = 1;
  logic        awready, wready, bvalid, arready, rvalid, cts_n, rxd, txd;
  logic        txa, rxe, pon, podd, two, rxc, irq;
  logic [1:0]  bresp, rresp;
  logic [34:0] exp_q[$];
  logic [34:0] e;
  int          mismatches = 0, checked = 0, seed = 72;

  ////////////////////////////////////////////////////////////////////////////
  always #2.5 clk = ~clk;

  ufcs_top u_dut (.CLK_SYS(clk), .RESET(rst), .CE(ce), .AWADDR(awaddr),
    .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
    .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .RX_CHAR_DONE(chr), .RX_FIRST_BYTE(first), .RX_MP_BIT(mp),
    .RX_DATA_READ(drd), .TXD_CORE(txc), .CTS_N(cts_n), .RXD_PIN(rxd),
    .TXD_PIN(txd), .TX_ALLOW(txa), .RX_ENABLE(rxe), .PARITY_ON(pon),
    .PARITY_ODD(podd), .TWO_STOP(two), .RXD_TO_CORE(rxc), .IRQ(irq));

  ufcs_remote u_remote (.clk(clk), .stall(stall), .send(send), .data(8'h00),
    .cts_n(cts_n), .rxd(rxd));

  ////////////////////////////////////////////////////////////////////////////
  // bus tasks note the expected answer, the monitor judges it
  task automatic wr(input logic [13:0] a, input logic [7:0] d,
                    input logic [3:0] s, input logic [1:0] r);
    bit aw, w;
    aw = 0;
    w = 0;
    @(posedge clk);
    exp_q.push_back({1'b0, r, 32'h0});
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (awready) begin aw = 1; awvalid <= 0; end
      if (wready) begin w = 1; wvalid <= 0; end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 0;
  endtask

  task automatic rd(input logic [13:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    exp_q.push_back({1'b1, r, d});
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 0;
  endtask

  // one receive-core event, with an optional data-register read
  task automatic ev(input logic f, input logic m, input logic c, input logic r);
    @(posedge clk);
    chr <= c;
    first <= f;
    mp <= m;
    drd <= r;
    @(posedge clk);
    chr <= 0;
    drd <= 0;
  endtask

  task automatic wt;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // program a line setting while disabled, enable it, then check the outputs
  task automatic cfg(input logic [7:0] v, input logic cts, input logic tc);
    logic lp;
    @(posedge clk);
    stall <= cts;
    txc <= tc;
    wr(A_CTL, 8'h00, 4'h1, OK);
    wr(A_CTL, v & 8'h3f, 4'h1, OK);
    wr(A_CTL, v, 4'h1, OK);
    repeat (4) @(posedge clk);
    #1;
    lp = v[2] ? 1'b0 : tc;
    `CHK("tx_allow", v[7] & (~v[5] | ~cts), txa)
    `CHK("rx_enable", v[6], rxe)
    `CHK("parity", v[4:3], {pon, podd})
    `CHK("two_stop", v[1], two)
    `CHK("txd_pin", lp, txd)
    `CHK("rxd_core", v[0] ? lp : 1'b1, rxc)
    rd(A_CTL, {24'h0, v}, OK);
  endtask

  task automatic finish_test;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // answer monitor, oldest note first
  always @(posedge clk) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      if (exp_q.size() == 0) begin
        mismatches++;
        $display("ERROR queue exp 1 got 0");
      end else begin
        e = exp_q.pop_front();
        `CHK("resp", e[33:32], rvalid ? rresp : bresp)
        if (rvalid) `CHK("rdata", e[31:0], rdata)
      end
    end
  end

  // hang guard, far beyond the expected run of a few hundred cycles
  initial begin
    #100000;
    mismatches++;
    finish_test;
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    rd(A_CTL, 32'h0, OK);
    rd(A_ST, 32'h0, OK);
    rd(14'h3d00, 32'h0, UFCS_RESP_SLVERR);
    wr(14'h3d00, 8'hff, 4'h1, UFCS_RESP_SLVERR);
    cfg(8'ha0, 1'b1, 1'b1);
    cfg(8'ha0, 1'b0, 1'b1);
    cfg(8'h84, 1'b1, 1'b1);
    cfg(8'h41, 1'b0, 1'b1);
    for (int i = 0; i < 12; i++) cfg(8'($random(seed)), 1'($random(seed)), 1'($random(seed)));
    wr(A_CTL, 8'h00, 4'h1, OK);
    // remote frame reaches the receiver path with loopback off
    @(posedge clk);
    send <= 1;
    @(posedge clk);
    send <= 0;
    for (int n = 0; n < 8 && rxc !== 1'b0; n++) @(posedge clk);
    `CHK("rx_path", 1'b0, rxc)
    repeat (12) @(posedge clk);
    // multidrop status set, clear and same-cycle collision
    ev(1, 1, 1, 0);
    rd(A_ST, 32'h3, OK);
    ev(0, 0, 0, 1);
    rd(A_ST, 32'h0, OK);
    ev(0, 1, 1, 0);
    rd(A_ST, 32'h1, OK);
    ev(1, 0, 1, 1);
    rd(A_ST, 32'h2, OK);
    wr(A_ST, 8'hff, 4'h1, OK);
    rd(A_ST, 32'h2, OK);
    wr(A_CTL, 8'h55, 4'h0, OK);
    rd(A_CTL, 32'h0, OK);
    // interrupt raised, masked and cleared per bit
    `CHK("irq", 1'b0, irq)
    rd(A_IS, 32'h3, OK);
    for (int b = 0; b < 2; b++) begin
      wr(A_IM, 8'(1 << b), 4'h1, OK);
      wt();
      `CHK("irq", 1'b1, irq)
      wr(A_IS, 8'(1 << b), 4'h1, OK);
      wt();
      `CHK("irq", 1'b0, irq)
    end
    // clock enable low must freeze the status and interrupt flags
    @(posedge clk);
    ce <= 0;
    ev(0, 1, 1, 1);
    @(posedge clk);
    ce <= 1;
    rd(A_ST, 32'h2, OK);
    rd(A_IS, 32'h0, OK);
    wt();
    finish_test;
  end
endmodule

// ---- sim/ufcs_remote.sv ----
/*
  ufcs_remote: far-end serial transceiver, sends one 8n1 frame per send pulse, one bit per clock.
  assumes the bench drives stall and send on its own clock edges.
*/
module ufcs_remote (
  // clock and control
  input  wire logic       clk,
  input  wire logic       stall,
  input  wire logic       send,
  input  wire logic [7:0] data,
  // serial pins
  output logic            cts_n,
  output logic            rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] sh_q  = 10'h3ff;
  logic [3:0] cnt_q = 4'h0;

  // peer holds us off by raising its clear-to-send line
  assign cts_n = stall;
  // line idles at mark so a released line never looks like a start bit
  assign rxd   = (cnt_q == 4'h0) ? 1'b1 : sh_q[0];

  // start bit, data lsb first, one stop bit
  always_ff @(posedge clk) begin
    if (send && cnt_q == 4'h0) begin
      sh_q  <= {1'b1, data, 1'b0};
      cnt_q <= 4'ha;
    end else if (cnt_q != 4'h0) begin
      sh_q  <= {1'b1, sh_q[9:1]};
      cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule

// ---- verilog/ufcs_pkg.sv ----
/*
  ufcs_pkg: register indices, field positions, reset values and bus codes
  for the serial frame control and status block.
  assumes a 32-bit axi4-lite bus, one register per aligned word.
*/
package ufcs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices; byte address is four times the index
  localparam logic [11:0] UFCS_IDX_CTRL0  = 12'hf42;
  localparam logic [11:0] UFCS_IDX_STAT1  = 12'hf44;
  localparam logic [11:0] UFCS_IDX_IRQST  = 12'hf48;
  localparam logic [11:0] UFCS_IDX_IRQMSK = 12'hf49;
  localparam int          UFCS_ADDR_W     = 14;

  ////////////////////////////////////////////////////////////////////////////
  // line control field positions
  localparam int UFCS_C_TXEN   = 7;
  localparam int UFCS_C_RXEN   = 6;
  localparam int UFCS_C_FLOW   = 5;
  localparam int UFCS_C_PAR    = 4;
  localparam int UFCS_C_ODD    = 3;
  localparam int UFCS_C_BRK    = 2;
  localparam int UFCS_C_STOP2  = 1;
  localparam int UFCS_C_LOOP   = 0;

  // multidrop status and interrupt field positions
  localparam int UFCS_S_FRAME  = 1;
  localparam int UFCS_S_MPBIT  = 0;
  localparam int UFCS_I_CHAR   = 0;
  localparam int UFCS_I_FRAME  = 1;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] UFCS_RST_CTRL0 = 8'h00;
  localparam logic [7:0] UFCS_RST_STAT1 = 8'h00;
  localparam logic [1:0] UFCS_RST_IRQ   = 2'h0;

  // bus responses
  localparam logic [1:0] UFCS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] UFCS_RESP_SLVERR = 2'h2;

endpackage

// ---- verilog/ufcs_top.sv ----
/*
  ufcs_top: configuration and multidrop status of an asynchronous serial
  transceiver, with an axi4-lite register slave and one level interrupt.
  assumes the shift registers and baud logic sit outside on CLK_SYS, and
  that the serial pins come from another domain and are synchronised here.
*/
// The AXI4-Lite interface to the registers was decided locally.
module ufcs_top
  import ufcs_pkg::*;
(
  // clock, reset, enable
  input  wire logic                   CLK_SYS,
  input  wire logic                   RESET,
  input  wire logic                   CE,
  // axi4-lite write address and data
  input  wire logic [UFCS_ADDR_W-1:0] AWADDR,
  input  wire logic                   AWVALID,
  output logic                        AWREADY,
  input  wire logic [31:0]            WDATA,
  input  wire logic [3:0]             WSTRB,
  input  wire logic                   WVALID,
  output logic                        WREADY,
  // axi4-lite write response
  output logic [1:0]                  BRESP,
  output logic                        BVALID,
  input  wire logic                   BREADY,
  // axi4-lite read
  input  wire logic [UFCS_ADDR_W-1:0] ARADDR,
  input  wire logic                   ARVALID,
  output logic                        ARREADY,
  output logic [31:0]                 RDATA,
  output logic [1:0]                  RRESP,
  output logic                        RVALID,
  input  wire logic                   RREADY,
  // receive core events, same clock
  input  wire logic                   RX_CHAR_DONE,
  input  wire logic                   RX_FIRST_BYTE,
  input  wire logic                   RX_MP_BIT,
  input  wire logic                   RX_DATA_READ,
  // transmit core serial stream, same clock
  input  wire logic                   TXD_CORE,
  // serial pins
  input  wire logic                   CTS_N,
  input  wire logic                   RXD_PIN,
  output logic                        TXD_PIN,
  // configuration to the shift logic
  output logic                        TX_ALLOW,
  output logic                        RX_ENABLE,
  output logic                        PARITY_ON,
  output logic                        PARITY_ODD,
  output logic                        TWO_STOP,
  output logic                        RXD_TO_CORE,
  // interrupt
  output logic                        IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // word index of a byte address
  function automatic logic [11:0] ufcs_idx(input logic [UFCS_ADDR_W-1:0] a);
    ufcs_idx = a[UFCS_ADDR_W-1:2];
  endfunction

  // true when an index lands on a mapped register
  function automatic logic ufcs_hit(input logic [11:0] i);
    ufcs_hit = (i == UFCS_IDX_CTRL0) || (i == UFCS_IDX_STAT1) ||
               (i == UFCS_IDX_IRQST) || (i == UFCS_IDX_IRQMSK);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: stage one feeds stage two only
  logic cts_s1_q, cts_s2_q;
  logic rxd_s1_q, rxd_s2_q;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      cts_s1_q <= 1'b1;
      cts_s2_q <= 1'b1;
      rxd_s1_q <= 1'b1;
      rxd_s2_q <= 1'b1;
    end else if (CE) begin
      cts_s1_q <= CTS_N;
      cts_s2_q <= cts_s1_q;
      rxd_s1_q <= RXD_PIN;
      rxd_s2_q <= rxd_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake state
  logic [7:0]  ctrl_q;
  logic        frame_q, mpbit_q;
  logic [1:0]  irq_st_q, irq_msk_q;
  logic        wtake_q, bvalid_q, rtake_q, rvalid_q;
  logic [11:0] widx_q, ridx_q;
  logic [31:0] rdata_q;
  logic [1:0]  bresp_q, rresp_q;

  // both write channels are taken together, one cycle after both are valid
  wire         wr_go   = AWVALID & WVALID & ~wtake_q & ~bvalid_q;
  wire         wr_fire = wtake_q;
  wire [11:0]  wr_idx  = widx_q;
  wire         wr_lane = WSTRB[0];
  wire [7:0]   wr_byte = WDATA[7:0];
  wire         rd_go   = ARVALID & ~rtake_q & ~rvalid_q;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      wtake_q  <= 1'b0;
      widx_q   <= 12'h000;
      bvalid_q <= 1'b0;
      bresp_q  <= UFCS_RESP_OKAY;
    end else if (CE) begin
      wtake_q <= wr_go;
      if (wr_go)
        widx_q <= ufcs_idx(AWADDR);
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= ufcs_hit(wr_idx) ? UFCS_RESP_OKAY : UFCS_RESP_SLVERR;
      end else if (BREADY)
        bvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write decode
  wire we_ctrl = wr_fire & wr_lane & (wr_idx == UFCS_IDX_CTRL0);
  wire we_ist  = wr_fire & wr_lane & (wr_idx == UFCS_IDX_IRQST);
  wire we_msk  = wr_fire & wr_lane & (wr_idx == UFCS_IDX_IRQMSK);

  // line control; written only while disabled by software convention
  always_ff @(posedge CLK_SYS) begin
    if (RESET)
      ctrl_q <= UFCS_RST_CTRL0;
    else if (CE && we_ctrl)
      ctrl_q <= wr_byte;
  end

  ////////////////////////////////////////////////////////////////////////////
  // multidrop status; a new character beats a same-cycle data read
  wire frame_d = RX_CHAR_DONE ? RX_FIRST_BYTE : (RX_DATA_READ ? 1'b0 : frame_q);
  wire mpbit_d = RX_CHAR_DONE ? RX_MP_BIT : (RX_DATA_READ ? 1'b0 : mpbit_q);

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      frame_q <= UFCS_RST_STAT1[UFCS_S_FRAME];
      mpbit_q <= UFCS_RST_STAT1[UFCS_S_MPBIT];
    end else if (CE) begin
      frame_q <= frame_d;
      mpbit_q <= mpbit_d;
    end
  end

  // status word; reserved bits tied low, writes ignored
  wire [7:0] stat_word = {6'h00, frame_q, mpbit_q};

  ////////////////////////////////////////////////////////////////////////////
  // sticky interrupt status, write one to clear, events win over clears
  wire [1:0] irq_ev = {RX_CHAR_DONE & RX_FIRST_BYTE, RX_CHAR_DONE};
  wire [1:0] irq_cl = we_ist ? wr_byte[1:0] : 2'h0;
  wire [1:0] irq_st_d = irq_ev | (irq_st_q & ~irq_cl);
  wire       irq_d = |(irq_st_d & irq_msk_q);

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      irq_st_q  <= UFCS_RST_IRQ;
      irq_msk_q <= UFCS_RST_IRQ;
    end else if (CE) begin
      irq_st_q <= irq_st_d;
      if (we_msk)
        irq_msk_q <= wr_byte[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path; unmapped words answer slverr with zero data
  wire [11:0] rd_idx = ridx_q;
  wire [7:0]  rd_byte =
    (rd_idx == UFCS_IDX_CTRL0)  ? ctrl_q :
    (rd_idx == UFCS_IDX_STAT1)  ? stat_word :
    (rd_idx == UFCS_IDX_IRQST)  ? {6'h00, irq_st_q} :
    (rd_idx == UFCS_IDX_IRQMSK) ? {6'h00, irq_msk_q} : 8'h00;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      rtake_q  <= 1'b0;
      ridx_q   <= 12'h000;
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= UFCS_RESP_OKAY;
    end else if (CE) begin
      rtake_q <= rd_go;
      if (rd_go)
        ridx_q <= ufcs_idx(ARADDR);
      if (rtake_q) begin
        rvalid_q <= 1'b1;
        rdata_q  <= {24'h00_0000, rd_byte};
        rresp_q  <= ufcs_hit(rd_idx) ? UFCS_RESP_OKAY : UFCS_RESP_SLVERR;
      end else if (RREADY)
        rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line and configuration outputs, all registered
  logic tx_allow_q, rx_en_q, par_q, odd_q, stop2_q, txd_q, rxd_core_q, irq_q;

  // flow gate: cts ignored unless gating is on; cts is active low
  wire tx_allow_d = ctrl_q[UFCS_C_TXEN] &
                    (~ctrl_q[UFCS_C_FLOW] | ~cts_s2_q);
  // break overrides the transmit stream; idle line is high
  wire txd_d      = ctrl_q[UFCS_C_BRK] ? 1'b0 : TXD_CORE;
  // loopback feeds the outgoing line state back into the receiver
  wire rxd_core_d = ctrl_q[UFCS_C_LOOP] ? txd_d : rxd_s2_q;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      tx_allow_q <= 1'b0;
      rx_en_q    <= 1'b0;
      par_q      <= 1'b0;
      odd_q      <= 1'b0;
      stop2_q    <= 1'b0;
      txd_q      <= 1'b1;
      rxd_core_q <= 1'b1;
      irq_q      <= 1'b0;
    end else if (CE) begin
      tx_allow_q <= tx_allow_d;
      rx_en_q    <= ctrl_q[UFCS_C_RXEN];
      par_q      <= ctrl_q[UFCS_C_PAR];
      odd_q      <= ctrl_q[UFCS_C_ODD];
      stop2_q    <= ctrl_q[UFCS_C_STOP2];
      txd_q      <= txd_d;
      rxd_core_q <= rxd_core_d;
      irq_q      <= irq_d;
    end
  end

  // port drive
  assign AWREADY     = wtake_q;
  assign WREADY      = wtake_q;
  assign BVALID      = bvalid_q;
  assign BRESP       = bresp_q;
  assign ARREADY     = rtake_q;
  assign RVALID      = rvalid_q;
  assign RDATA       = rdata_q;
  assign RRESP       = rresp_q;
  assign TX_ALLOW    = tx_allow_q;
  assign RX_ENABLE   = rx_en_q;
  assign PARITY_ON   = par_q;
  assign PARITY_ODD  = odd_q;
  assign TWO_STOP    = stop2_q;
  assign TXD_PIN     = txd_q;
  assign RXD_TO_CORE = rxd_core_q;
  assign IRQ         = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking ufcs_cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  sequence s_status_read;
    CE && rtake_q && (rd_idx == UFCS_IDX_STAT1);
  endsequence

  sequence s_write_taken;
    CE && wtake_q;
  endsequence

  a_reserved_read_zero: assert property (
    s_status_read |=> (RVALID && RDATA[31:2] == 30'h0000_0000))
    else $error("reserved status bits read nonzero");

  a_frame_flag_set: assert property (
    (CE && RX_CHAR_DONE && RX_FIRST_BYTE) |=> frame_q)
    else $error("frame start flag not set");

  a_frame_flag_clear: assert property (
    (CE && RX_DATA_READ && !RX_CHAR_DONE) |=> !frame_q)
    else $error("frame start flag not cleared by data read");

  a_mp_bit_track: assert property (
    (CE && RX_CHAR_DONE) |=> (mpbit_q == $past(RX_MP_BIT)))
    else $error("multidrop bit does not follow received character");

  a_mp_bit_clear: assert property (
    (CE && RX_DATA_READ && !RX_CHAR_DONE) |=> !mpbit_q)
    else $error("multidrop bit not cleared by data read");

  a_tx_off_gate: assert property (
    (CE && !ctrl_q[UFCS_C_TXEN]) |=> !TX_ALLOW)
    else $error("transmitter allowed while disabled");

  a_cts_gate_block: assert property (
    (CE && ctrl_q[UFCS_C_FLOW] && cts_s2_q) |=> !TX_ALLOW)
    else $error("transmitter allowed with clear-to-send high");

  a_cts_ignored: assert property (
    (CE && !ctrl_q[UFCS_C_FLOW] && ctrl_q[UFCS_C_TXEN]) |=> TX_ALLOW)
    else $error("clear-to-send blocked an ungated transmitter");

  a_rx_enable_follow: assert property (
    CE |=> (RX_ENABLE == $past(ctrl_q[UFCS_C_RXEN])))
    else $error("receiver enable does not follow control");

  a_break_holds_line: assert property (
    (CE && ctrl_q[UFCS_C_BRK]) [*2] |=> !TXD_PIN)
    else $error("break did not hold line low");

  a_loop_route: assert property (
    (CE && ctrl_q[UFCS_C_LOOP]) |=> (RXD_TO_CORE == TXD_PIN))
    else $error("loopback does not feed transmit line to receiver");

  a_write_resp_time: assert property (
    s_write_taken |=> BVALID)
    else $error("write response late");

  a_irq_level_mask: assert property (
    (CE && !(|(irq_st_q & irq_msk_q)) && !(|irq_ev)) |=> !IRQ)
    else $error("interrupt raised with nothing unmasked");

endmodule
